/* inc/lrc_pkg.sv */
// Constants shared by the linefeed and ringing control register block.
// Assumes a 25 MHz clock and word-aligned AHB-Lite register indices.
// Summary of operation
// RULE_01: Silent timer is two RW bytes, 125us counts.
// RULE_02: Silent high byte and caller-ID data reset zero.
// RULE_03: Both enables set: data bit0 feeds bit stream.
// RULE_04: Silent period debounce, 1.25 ms steps.
// RULE_05: Line state select field bits 2:0 sets state.
// RULE_06: Read-only shadow bits 6:4 shows actual state.
// RULE_07: Ringing: shadow shows on-hook transmission when silent.
// RULE_08: Bit 6 mutes both transmit audio outputs.
// RULE_09: Bit 5 bypasses both loop filter capacitors.
// RULE_10: Bit 4 enables external transistor bias current.
// RULE_11: Bits 3:2 pick on-hook transmission bias.
// RULE_12: Bits 1:0 pick active off-hook bias.
// RULE_13: Burst timer is two RW bytes, 125us counts.
// RULE_14: Cadence alternates burst and silent by timers.
// RULE_15: Reserved bits read zero, ignore writes.
package lrc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_BURST_LO = 8'h30;
  localparam logic [7:0] IDX_BURST_HI = 8'h31;
  localparam logic [7:0] IDX_SILENT_LO = 8'h32;
  localparam logic [7:0] IDX_SILENT_HI = 8'h33;
  localparam logic [7:0] IDX_CALLERID = 8'h34;
  localparam logic [7:0] IDX_DEBOUNCE = 8'h3f;
  localparam logic [7:0] IDX_LINE_STATE = 8'h40;
  localparam logic [7:0] IDX_XTOR = 8'h41;
  localparam logic [7:0] IDX_OSC_CTRL = 8'h20;
  localparam logic [7:0] IDX_MOD_CTRL = 8'h6c;
  localparam logic [7:0] IDX_RING_STATUS = 8'h44;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = 8;
  // Field positions
  localparam int ENABLE_BIT = 6;
  localparam int MUTE_BIT = 6;
  localparam int BYPASS_BIT = 5;
  localparam int BIAS_EN_BIT = 4;
  localparam int ONHOOK_LSB = 2;
  localparam int OFFHOOK_LSB = 0;
  localparam int SHADOW_LSB = 4;
  localparam int STAT_LOOP_BIT = 0;
  localparam int STAT_BURST_BIT = 1;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_DEBOUNCE = 8'h54;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 125000;
  localparam int STEP_NS = 1250000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int TICKS_PER_STEP = STEP_NS / TICK_NS;
  localparam int DEB_W = 12;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  typedef enum logic [2:0] {
    LS_OPEN = 3'b000,
    LS_FWD_ACTIVE = 3'b001,
    LS_FWD_OHT = 3'b010,
    LS_TIP_OPEN = 3'b011,
    LS_RINGING = 3'b100,
    LS_REV_ACTIVE = 3'b101,
    LS_REV_OHT = 3'b110,
    LS_RING_OPEN = 3'b111
  } lrc_line_t;
  typedef enum logic [1:0] {
    CAD_IDLE = 2'b00,
    CAD_BURST = 2'b01,
    CAD_SILENT = 2'b11
  } lrc_cad_t;
endpackage

/* hw/lrc_tick_gen.sv */
// Free-running prescaler giving a one-cycle pulse every PERIOD clocks.
// Assumes a single clock domain with asynchronous active-high reset.
`timescale 1ns/1ps
module lrc_tick_gen import lrc_pkg::*; #(
  parameter int PERIOD = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  localparam int W = $clog2(PERIOD);
  localparam logic [W-1:0] LAST = W'(PERIOD - 1);
  logic [W-1:0] count;

  initial begin
    if (PERIOD < 2) begin
      $error("lrc_tick_gen: PERIOD must be at least 2");
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign tick = (count == LAST);
endmodule

/* hw/lrc_tick_counter.sv */
// Loadable down-counter stepped by tick pulses; done while it is zero.
// Assumes load and tick come from the same clock domain.
`timescale 1ns/1ps
module lrc_tick_counter #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] loadValue,
  output logic done
);
  logic [W-1:0] count;

  initial begin
    if (W < 1) begin
      $error("lrc_tick_counter: W must be positive");
    end
  end

  // Load wins over a tick in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (load) begin
      count <= loadValue;
    end else if (tick && count != '0) begin
      count <= count - 1'b1;
    end
  end

  assign done = (count == '0);
endmodule

/* hw/lrc_regs.sv */
// Linefeed, ringing cadence, caller-ID bit and bias control registers.
// Assumes a single AHB-Lite master, word accesses only, one 25 MHz clock.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module lrc_regs import lrc_pkg::*; #(
  parameter logic [7:0] DEBOUNCE_RESET = RST_DEBOUNCE
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic loopClosureRaw,
  input wire logic callerIdBitTake,
  output logic callerIdBit,
  output logic ringBurst,
  output logic [2:0] lineStateShadow,
  output logic audioMute,
  output logic capBypass,
  output logic xtorBiasEnable,
  output logic [1:0] xtorBiasOnhook,
  output logic [1:0] xtorBiasOffhook
);
  logic [15:0] ringBurstTimer;
  logic [15:0] ringSilentTimer;
  logic callerIdBitIn;
  logic [7:0] silentPeriodDebounce;
  lrc_line_t lineStateSelect;
  logic [6:0] xtorControl;
  logic ringOscEnable;
  logic callerIdModulationEnable;
  logic wrPending;
  logic [IDX_W-1:0] wrIdx;
  logic [IDX_W-1:0] rdIdx;
  logic addrPhase;
  logic [31:0] next_hrdata;
  lrc_cad_t cadState;
  lrc_cad_t next_cadState;
  logic cadLoad;
  logic [15:0] cadLoadValue;
  logic cadDone;
  logic tick;
  logic ringCadence;
  logic debLoad;
  logic debDone;
  logic [DEB_W-1:0] debTicks;
  logic loopClosedSilent;
  logic wrEn;

  // Zero wait states and always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Only aligned word transfers are decoded; others complete and are ignored
  assign addrPhase = hsel && hready && htrans == HTRANS_NONSEQ
    && hsize == HSIZE_WORD && haddr[ADDR_LSB-1:0] == '0;
  assign rdIdx = haddr[ADDR_LSB +: IDX_W];
  assign wrEn = wrPending;

  // The largest debounce code must still fit the debounce counter
  initial begin
    if ((2 ** $bits(silentPeriodDebounce)) * TICKS_PER_STEP > (2 ** DEB_W)) begin
      $error("lrc_regs: DEB_W too narrow for the debounce range");
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPending <= 1'b0;
      wrIdx <= '0;
    end else begin
      wrPending <= addrPhase && hwrite;
      wrIdx <= rdIdx;
    end
  end

  // Read data is captured at the address phase so hrdata comes from a flop
  always_comb begin
    next_hrdata = '0;
    case (rdIdx)
      IDX_BURST_LO: next_hrdata[7:0] = ringBurstTimer[7:0]; // RULE_13
      IDX_BURST_HI: next_hrdata[7:0] = ringBurstTimer[15:8]; // RULE_13
      IDX_SILENT_LO: next_hrdata[7:0] = ringSilentTimer[7:0]; // RULE_01
      IDX_SILENT_HI: next_hrdata[7:0] = ringSilentTimer[15:8]; // RULE_01
      IDX_CALLERID: next_hrdata[0] = callerIdBitIn; // RULE_15
      IDX_DEBOUNCE: next_hrdata[7:0] = silentPeriodDebounce;
      IDX_LINE_STATE: begin
        next_hrdata[SHADOW_LSB +: 3] = lineStateShadow; // RULE_06
        next_hrdata[2:0] = lineStateSelect;
      end
      IDX_XTOR: next_hrdata[6:0] = xtorControl; // RULE_15
      IDX_OSC_CTRL: next_hrdata[ENABLE_BIT] = ringOscEnable;
      IDX_MOD_CTRL: next_hrdata[ENABLE_BIT] = callerIdModulationEnable;
      IDX_RING_STATUS: begin
        next_hrdata[STAT_LOOP_BIT] = loopClosedSilent;
        next_hrdata[STAT_BURST_BIT] = ringBurst;
      end
      default: next_hrdata = '0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= '0;
    end else if (addrPhase && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ringBurstTimer <= {RST_BYTE, RST_BYTE};
      ringSilentTimer <= {RST_BYTE, RST_BYTE}; // RULE_02
    end else if (wrEn) begin
      if (wrIdx == IDX_BURST_LO) ringBurstTimer[7:0] <= hwdata[7:0]; // RULE_13
      if (wrIdx == IDX_BURST_HI) ringBurstTimer[15:8] <= hwdata[7:0]; // RULE_13
      if (wrIdx == IDX_SILENT_LO) ringSilentTimer[7:0] <= hwdata[7:0]; // RULE_01
      if (wrIdx == IDX_SILENT_HI) ringSilentTimer[15:8] <= hwdata[7:0]; // RULE_01
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      callerIdBitIn <= 1'b0; // RULE_02
      callerIdModulationEnable <= 1'b0;
      ringOscEnable <= 1'b0;
    end else if (wrEn) begin
      if (wrIdx == IDX_CALLERID) callerIdBitIn <= hwdata[0]; // RULE_15
      if (wrIdx == IDX_MOD_CTRL) callerIdModulationEnable <= hwdata[ENABLE_BIT];
      if (wrIdx == IDX_OSC_CTRL) ringOscEnable <= hwdata[ENABLE_BIT];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      silentPeriodDebounce <= DEBOUNCE_RESET;
      lineStateSelect <= LS_OPEN;
      xtorControl <= '0;
    end else if (wrEn) begin
      if (wrIdx == IDX_DEBOUNCE) silentPeriodDebounce <= hwdata[7:0]; // RULE_04
      if (wrIdx == IDX_LINE_STATE) lineStateSelect <= lrc_line_t'(hwdata[2:0]); // RULE_05
      if (wrIdx == IDX_XTOR) xtorControl <= hwdata[6:0]; // RULE_15
    end
  end

  // Generator pulls the next bit; the buffered value is only taken when enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      callerIdBit <= 1'b0;
    end else if (callerIdBitTake && callerIdModulationEnable && ringOscEnable) begin
      callerIdBit <= callerIdBitIn; // RULE_03
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      audioMute <= 1'b0;
      capBypass <= 1'b0;
      xtorBiasEnable <= 1'b0;
      xtorBiasOnhook <= '0;
      xtorBiasOffhook <= '0;
    end else begin
      audioMute <= xtorControl[MUTE_BIT]; // RULE_08
      capBypass <= xtorControl[BYPASS_BIT]; // RULE_09
      xtorBiasEnable <= xtorControl[BIAS_EN_BIT]; // RULE_10
      // Code 11 is passed through; the bias stage treats it as reserved
      xtorBiasOnhook <= xtorControl[ONHOOK_LSB +: 2]; // RULE_11
      xtorBiasOffhook <= xtorControl[OFFHOOK_LSB +: 2]; // RULE_12
    end
  end

  lrc_tick_gen #(
    .PERIOD(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  assign ringCadence = lineStateSelect == LS_RINGING && ringOscEnable;

  // A zero burst or silent time means continuous ringing
  always_comb begin
    next_cadState = cadState;
    cadLoad = 1'b0;
    cadLoadValue = ringBurstTimer;
    case (cadState)
      CAD_IDLE: begin
        if (ringCadence) begin
          next_cadState = CAD_BURST;
          cadLoad = 1'b1;
        end
      end
      CAD_BURST: begin
        if (!ringCadence) begin
          next_cadState = CAD_IDLE;
        end else if (cadDone && ringBurstTimer != '0 && ringSilentTimer != '0) begin
          next_cadState = CAD_SILENT; // RULE_14
          cadLoad = 1'b1;
          cadLoadValue = ringSilentTimer;
        end
      end
      CAD_SILENT: begin
        if (!ringCadence) begin
          next_cadState = CAD_IDLE;
        end else if (cadDone) begin
          next_cadState = CAD_BURST; // RULE_14
          cadLoad = 1'b1;
        end
      end
      default: next_cadState = CAD_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cadState <= CAD_IDLE;
    end else begin
      cadState <= next_cadState;
    end
  end

  lrc_tick_counter #(
    .W(16)
  ) u_cadence (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .load(cadLoad),
    .loadValue(cadLoadValue),
    .done(cadDone)
  );

  assign ringBurst = cadState == CAD_BURST;

  // Shadow follows the select except for the silent gap of a ring cadence
  always_comb begin
    if (lineStateSelect == LS_RINGING && cadState == CAD_SILENT) begin
      lineStateShadow = LS_FWD_OHT; // RULE_07
    end else begin
      lineStateShadow = lineStateSelect; // RULE_06
    end
  end

  // Debounce restarts whenever the loop opens or the silent period ends
  assign debTicks = DEB_W'(silentPeriodDebounce * TICKS_PER_STEP);
  assign debLoad = !(cadState == CAD_SILENT && loopClosureRaw); // RULE_04

  lrc_tick_counter #(
    .W(DEB_W)
  ) u_debounce (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .load(debLoad),
    .loadValue(debTicks),
    .done(debDone)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loopClosedSilent <= 1'b0;
    end else begin
      loopClosedSilent <= !debLoad && debDone; // RULE_04
    end
  end

  sequence s_burst_end;
    cadState == CAD_BURST && cadDone && ringCadence
      && ringBurstTimer != '0 && ringSilentTimer != '0;
  endsequence

  sequence s_silent_end;
    cadState == CAD_SILENT && cadDone && ringCadence;
  endsequence

  a_burst_to_silent: assert property (@(posedge clk) disable iff (rst) // RULE_14
    s_burst_end |=> cadState == CAD_SILENT && !ringBurst)
    else $error("burst did not hand over to silent period");

  a_silent_to_burst: assert property (@(posedge clk) disable iff (rst) // RULE_14
    s_silent_end |=> ringBurst)
    else $error("silent period did not return to burst");

  a_shadow_silent: assert property (@(posedge clk) disable iff (rst) // RULE_07
    cadState == CAD_SILENT && lineStateSelect == LS_RINGING |-> lineStateShadow == LS_FWD_OHT)
    else $error("shadow wrong during silent period");

  a_shadow_follows: assert property (@(posedge clk) disable iff (rst) // RULE_06
    wrEn && wrIdx == IDX_LINE_STATE && hwdata[2:0] != LS_RINGING
      |=> lineStateShadow == $past(hwdata[2:0]))
    else $error("shadow does not follow written line state");

  a_callerid_take: assert property (@(posedge clk) disable iff (rst) // RULE_03
    callerIdBitTake && callerIdModulationEnable && ringOscEnable
      |=> callerIdBit == $past(callerIdBitIn))
    else $error("caller-ID bit not taken");

  a_callerid_hold: assert property (@(posedge clk) disable iff (rst) // RULE_03
    !(callerIdBitTake && callerIdModulationEnable && ringOscEnable)
      |=> $stable(callerIdBit))
    else $error("caller-ID bit changed while not enabled");

  a_mute_write: assert property (@(posedge clk) disable iff (rst) // RULE_08
    wrEn && wrIdx == IDX_XTOR |=> ##1 audioMute == $past(hwdata[MUTE_BIT], 2)
      && capBypass == $past(hwdata[BYPASS_BIT], 2))
    else $error("mute or bypass output does not track register");

  a_silent_timer_wr: assert property (@(posedge clk) disable iff (rst) // RULE_01
    wrEn && wrIdx == IDX_SILENT_HI |=> ringSilentTimer[15:8] == $past(hwdata[7:0]))
    else $error("silent timer high byte not written");

  a_reserved_zero: assert property (@(posedge clk) disable iff (rst) // RULE_15
    addrPhase && !hwrite && rdIdx == IDX_XTOR |=> hrdata[31:7] == '0)
    else $error("reserved bits read nonzero");

  a_debounce_gate: assert property (@(posedge clk) disable iff (rst) // RULE_04
    cadState != CAD_SILENT |=> !loopClosedSilent)
    else $error("loop closure reported outside silent period");

  a_burst_timer_wr: assert property (@(posedge clk) disable iff (rst) // RULE_13
    wrEn && wrIdx == IDX_BURST_HI |=> ringBurstTimer[15:8] == $past(hwdata[7:0]))
    else $error("burst timer high byte not written");

  a_line_write: assert property (@(posedge clk) disable iff (rst) // RULE_05
    wrEn && wrIdx == IDX_LINE_STATE |=> lineStateSelect == $past(hwdata[2:0]))
    else $error("line state select not written");

  a_bias_enable: assert property (@(posedge clk) disable iff (rst) // RULE_10
    wrEn && wrIdx == IDX_XTOR |=> ##1 xtorBiasEnable == $past(hwdata[BIAS_EN_BIT], 2))
    else $error("bias enable output does not track register");

  a_bias_onhook: assert property (@(posedge clk) disable iff (rst) // RULE_11
    wrEn && wrIdx == IDX_XTOR |=> ##1 xtorBiasOnhook == $past(hwdata[ONHOOK_LSB +: 2], 2))
    else $error("on-hook bias code does not track register");

  a_bias_offhook: assert property (@(posedge clk) disable iff (rst) // RULE_12
    wrEn && wrIdx == IDX_XTOR |=> ##1 xtorBiasOffhook == $past(hwdata[OFFHOOK_LSB +: 2], 2))
    else $error("off-hook bias code does not track register");

  a_reserved_line: assert property (@(posedge clk) disable iff (rst) // RULE_15
    addrPhase && !hwrite && rdIdx == IDX_LINE_STATE |=> hrdata[31:7] == '0 && !hrdata[3])
    else $error("line state reserved bits read nonzero");
endmodule

/* tb/lrc_bit_sink.sv */
// Model of the caller-ID bit-stream generator that pulls buffered bits.
// Assumes the bench raises pull for one cycle per wanted bit.
`timescale 1ns/1ps
module lrc_bit_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic pull,
  input wire logic bitIn,
  output logic take,
  output logic gotBit
);
  logic takeD;
  // One-cycle request, bit captured one cycle after the take
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      take <= 1'b0;
      takeD <= 1'b0;
      gotBit <= 1'b0;
    end else begin
      take <= pull & ~take;
      takeD <= take;
      if (takeD) begin
        gotBit <= bitIn;
      end
    end
  end
endmodule

/* tb/tb.sv */
// Self-checking bench for the linefeed and ringing control registers.
// Assumes the design answers with zero wait states on AHB-Lite.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module tb import lrc_pkg::*;;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b000;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, callerIdBitTake, callerIdBit, ringBurst;
  logic [31:0] hrdata;
  logic loopClosureRaw = 1'b0;
  logic pull = 1'b0;
  logic gotBit, audioMute, capBypass, xtorBiasEnable;
  logic [2:0] lineStateShadow;
  logic [1:0] xtorBiasOnhook, xtorBiasOffhook;
  int mismatches = 0;
  int num_checks = 0;

  always #20 clk = ~clk;

  lrc_regs i_lrc_regs (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .loopClosureRaw(loopClosureRaw),
    .callerIdBitTake(callerIdBitTake), .callerIdBit(callerIdBit), .ringBurst(ringBurst),
    .lineStateShadow(lineStateShadow), .audioMute(audioMute), .capBypass(capBypass),
    .xtorBiasEnable(xtorBiasEnable), .xtorBiasOnhook(xtorBiasOnhook),
    .xtorBiasOffhook(xtorBiasOffhook));
  lrc_bit_sink i_lrc_bit_sink (.clk(clk), .rst(rst), .pull(pull), .bitIn(callerIdBit),
    .take(callerIdBitTake), .gotBit(gotBit));

  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    `CHK(nm, {24'h0, exp}, q)
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic wait_burst(input logic lvl, output int n);
    n = 0;
    while (ringBurst !== lvl && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      `CHK("burst_wait", lvl, ringBurst)
      report_and_stop();
    end
  endtask
  task automatic take_chk(input logic exp);
    @(posedge clk);
    pull <= 1'b1;
    @(posedge clk);
    pull <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("callerid_bit", exp, gotBit)
  endtask

  task automatic t_reset();
    rd_chk("silent_hi_rst", IDX_SILENT_HI, 8'h00);
    rd_chk("callerid_rst", IDX_CALLERID, 8'h00);
    rd_chk("burst_hi_rst", IDX_BURST_HI, 8'h00);
    rd_chk("debounce_rst", IDX_DEBOUNCE, 8'h54);
    rd_chk("line_rst", IDX_LINE_STATE, 8'h00);
  endtask
  task automatic t_rw();
    wr(IDX_SILENT_LO, 8'ha5);
    wr(IDX_SILENT_HI, 8'h5a);
    wr(IDX_BURST_LO, 8'h3c);
    wr(IDX_BURST_HI, 8'hc3);
    wr(IDX_CALLERID, 8'hff);
    wr(IDX_DEBOUNCE, 8'h7f);
    wr(8'h10, 8'hff);
    rd_chk("silent_lo", IDX_SILENT_LO, 8'ha5);
    rd_chk("silent_hi", IDX_SILENT_HI, 8'h5a);
    rd_chk("burst_lo", IDX_BURST_LO, 8'h3c);
    rd_chk("burst_hi", IDX_BURST_HI, 8'hc3);
    rd_chk("callerid", IDX_CALLERID, 8'h01);
    rd_chk("debounce", IDX_DEBOUNCE, 8'h7f);
    rd_chk("unmapped", 8'h10, 8'h00);
  endtask
  task automatic t_line();
    for (int c = 0; c < 8; c++) begin
      if (c != 4) begin
        wr(IDX_LINE_STATE, 8'hf8 | 8'(c));
        rd_chk("line_state", IDX_LINE_STATE, {1'b0, 3'(c), 1'b0, 3'(c)});
        `CHK("shadow_port", 3'(c), lineStateShadow)
      end
    end
  endtask
  task automatic t_xtor();
    logic [7:0] v[3] = '{8'hff, 8'h26, 8'h59};
    for (int i = 0; i < 3; i++) begin
      wr(IDX_XTOR, v[i]);
      repeat (2) @(posedge clk);
      `CHK("xtor_mute", v[i][6], audioMute)
      `CHK("xtor_bypass", v[i][5], capBypass)
      `CHK("xtor_bias_en", v[i][4], xtorBiasEnable)
      `CHK("xtor_onhook", v[i][3:2], xtorBiasOnhook)
      `CHK("xtor_offhook", v[i][1:0], xtorBiasOffhook)
      rd_chk("xtor_reg", IDX_XTOR, v[i] & 8'h7f);
    end
  endtask
  task automatic t_callerid();
    wr(IDX_MOD_CTRL, 8'h40);
    wr(IDX_CALLERID, 8'h01);
    take_chk(1'b0);
    wr(IDX_OSC_CTRL, 8'h40);
    take_chk(1'b1);
    wr(IDX_CALLERID, 8'h00);
    take_chk(1'b0);
  endtask
  task automatic t_cadence();
    int n;
    wr(IDX_BURST_LO, 8'h02);
    wr(IDX_BURST_HI, 8'h00);
    wr(IDX_SILENT_LO, 8'h02);
    wr(IDX_SILENT_HI, 8'h00);
    wr(IDX_LINE_STATE, 8'h04);
    wait_burst(1'b1, n);
    `CHK("ring_shadow", 3'b100, lineStateShadow)
    wait_burst(1'b0, n);
    @(posedge clk);
    `CHK("silent_shadow", 3'b010, lineStateShadow)
    wait_burst(1'b1, n);
    `CHK("silent_len", 1'b1, n >= 6248 && n <= 6252)
    wait_burst(1'b0, n);
    `CHK("burst_len", 1'b1, n >= 6248 && n <= 6252)
    // Long silence so the 10-tick debounce finishes inside one period
    wr(IDX_SILENT_LO, 8'd20);
    wr(IDX_DEBOUNCE, 8'h01);
    wait_burst(1'b1, n);
    wait_burst(1'b0, n);
    loopClosureRaw <= 1'b1;
    repeat (8 * TICK_CYCLES) @(posedge clk);
    rd_chk("loop_early", IDX_RING_STATUS, 8'h00);
    repeat (3 * TICK_CYCLES) @(posedge clk);
    rd_chk("loop_closed", IDX_RING_STATUS, 8'h01);
    loopClosureRaw <= 1'b0;
    rd_chk("loop_open", IDX_RING_STATUS, 8'h00);
    wr(IDX_LINE_STATE, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("leave_ring", 4'b0001, {ringBurst, lineStateShadow})
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rw();
    t_line();
    t_xtor();
    t_callerid();
    t_cadence();
    report_and_stop();
  end
endmodule
